// >>> sim/iosr_core_assertions.sv
/*
 * Port checks on iosr_core: response framing, stall hold, command effects.
 * Assumes one clock and the synchronous active-low reset.
 */
module iosr_core_assertions
    import iosr_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = 20,
    parameter int unsigned TIMEOUT_CYCLES  = 2000
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic [7:0] rxData,
    input wire logic       rxValid,
    input wire logic [7:0] txData,
    input wire logic       txValid,
    input wire logic       txReady,
    input wire logic       abnormal,
    input wire logic       outCtrlStrobe,
    input wire logic       runMode
);
    logic [6:0] txIdx;

    ////////////////////////////////////////////////////////////////////////////
    // Byte position within the response in flight
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !txValid)
            txIdx <= 7'd0;
        else if (txReady)
            txIdx <= txIdx + 7'd1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////
    // Framing and payload layout
    chk_frame_start: assert property ($rose(txValid) |-> txData == CH_START)
        else $error("response does not open with start flag");
    chk_stall_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("response byte moved while stalled");
    chk_frame_len: assert property ($fell(txValid) |-> txIdx == 7'd61)
        else $error("response length is not 61 bytes");
    chk_rsp_head: assert property (txValid |-> (txIdx != 7'd1 || txData == 8'h33)
        && (txIdx != 7'd2 || txData == 8'h36) && (txIdx != 7'd3 || txData == CH_ZERO)
        && (txIdx != 7'd4 || txData == RSP_STATE))
        else $error("response length or code wrong");
    chk_ctrl_byte: assert property (txValid && txIdx == 7'd5 |->
        txData == (abnormal ? CS_ABNORMAL : (runMode ? CS_NORMAL : CS_NOT_RUN)))
        else $error("control state byte wrong");
    chk_comma_pos: assert property (txValid && txIdx inside
        {7'd11, 7'd17, 7'd23, 7'd29, 7'd34, 7'd39, 7'd44, 7'd49, 7'd54} |-> txData == CH_COMMA)
        else $error("separator missing");
    chk_frame_end: assert property (txValid && txIdx >= 7'd59 |->
        txData == ((txIdx == 7'd59) ? CH_CR : CH_LF))
        else $error("end flag wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Command side effects follow a frame end
    chk_strobe_cause: assert property (outCtrlStrobe |-> $past(rxValid) && $past(rxData) == CH_LF)
        else $error("output strobe without frame end");
    chk_mode_cause: assert property ($changed(runMode) |-> $past(rxValid) && $past(rxData) == CH_LF)
        else $error("mode changed without frame end");
endmodule

bind iosr_core iosr_core_assertions #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
) chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .rxData(rxData), .rxValid(rxValid),
    .txData(txData), .txValid(txValid), .txReady(txReady), .abnormal(abnormal),
    .outCtrlStrobe(outCtrlStrobe), .runMode(runMode)
);

// >>> sim/iosr_core_test.sv
/*
 * Self-checking bench for iosr_core: reports, commands, modes, bad frames.
 * Assumes short debounce and timeout counts set at the instance.
 */
`define CHK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s expected %0h got %0h", what, exp, got); end end
module iosr_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    import iosr_pkg::*;
    logic               clk_sys, reset_n, rxValid, txValid, txReady, abnormal;
    logic               outCtrlStrobe, runMode;
    logic [7:0]         rxData, txData, body[$];
    logic [NUM_DIN-1:0] digIn;
    logic [NUM_ANA-1:0] anaSwitchRaw, anaLevelMode;
    logic [39:0]        anaLevel;
    logic [29:0]        outState;
    logic [NUM_OUT-1:0] outCtrlMask, outCtrlOn, seenMask, seenOn;
    int                 errors, nChecks, nStrobe;

    iosr_core #(.DEBOUNCE_CYCLES(20), .TIMEOUT_CYCLES(2000)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .rxData(rxData), .rxValid(rxValid),
        .txData(txData), .txValid(txValid), .txReady(txReady), .digIn(digIn),
        .anaSwitchRaw(anaSwitchRaw), .anaLevelMode(anaLevelMode), .anaLevel(anaLevel),
        .outState(outState), .abnormal(abnormal), .outCtrlStrobe(outCtrlStrobe),
        .outCtrlMask(outCtrlMask), .outCtrlOn(outCtrlOn), .runMode(runMode));
    iosr_host_model host_u (.clk_sys(clk_sys), .rxData(rxData), .rxValid(rxValid),
        .txData(txData), .txValid(txValid), .txReady(txReady));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Catch output strobes mid-cycle
    always @(negedge clk_sys) begin
        if (outCtrlStrobe === 1'b1) begin
            nStrobe++;
            seenMask = outCtrlMask;
            seenOn   = outCtrlOn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expected state response from the present inputs
    function automatic void expFrame(input logic [7:0] ctrl, output logic [7:0] f[61]);
        logic [7:0] chk;
        int lvl;
        f = '{default: CH_COMMA};
        f[0] = CH_START;
        f[1] = 8'h33;
        f[2] = 8'h36;
        f[3] = CH_ZERO;
        f[4] = RSP_STATE;
        f[5] = ctrl;
        for (int a = 0; a < 4; a++) begin
            lvl = int'(anaLevel[10*a +: 10]);
            f[6+6*a] = anaLevelMode[a] ? CH_NINE : (anaSwitchRaw[a] ? CH_ONE : CH_ZERO);
            for (int d = 0; d < 4; d++) begin
                f[10+6*a-d] = 8'h30 + 8'(lvl % 10);
                lvl = lvl / 10;
            end
        end
        for (int i = 0; i < 12; i++) f[30+i+i/4] = digIn[i] ? CH_ONE : CH_ZERO;
        for (int i = 0; i < 10; i++) f[45+i+i/4] = 8'h30 + 8'(outState[3*i +: 3]);
        chk = LRC_SEED;
        for (int i = 1; i < 57; i++) chk ^= f[i];
        f[57] = host_u.hexChar(chk[7:4]);
        f[58] = host_u.hexChar(chk[3:0]);
        f[59] = CH_CR;
        f[60] = CH_LF;
    endfunction

    task automatic results();
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Wait for n responses, confirm silence after, compare bytes
    task automatic expectFrames(input int n, input logic [7:0] ctrl, input bit cmp);
        logic [7:0] f[61];
        int w;
        w = 0;
        while (host_u.got.size() < 61 * n && w < 4000) begin
            @(negedge clk_sys);
            w++;
        end
        if (host_u.got.size() < 61 * n) begin
            errors++;
            results();
        end
        repeat (300) @(negedge clk_sys);
        `CHK("response count", 61 * n, host_u.got.size())
        expFrame(ctrl, f);
        for (int k = 0; k < n && cmp; k++)
            foreach (f[i]) `CHK("response byte", f[i], host_u.got[61*k+i])
        host_u.got.delete();
    endtask

    task automatic cmd(input logic [7:0] fn, input logic [7:0] arg, input bit bad, input int gap);
        body = {CH_ZERO, fn, arg};
        host_u.sendCmd(body, bad, gap);
    endtask

    // Fresh inputs, at least one digital bit toggled
    task automatic newInputs();
        @(negedge clk_sys);
        digIn <= digIn ^ 12'($urandom_range(4095, 1));
        anaSwitchRaw <= 4'($urandom);
        for (int a = 0; a < 4; a++) anaLevel[10*a +: 10] <= 10'($urandom_range(1023));
        for (int i = 0; i < 10; i++) outState[3*i +: 3] <= 3'($urandom_range(5));
    endtask

    // Random batch on/off command and its strobe
    task automatic onOff(input int nRsp);
        logic [9:0] m;
        logic [9:0] o;
        m = 10'($urandom);
        o = 10'($urandom);
        body = {CH_ZERO, CMD_ONOFF};
        for (int i = 0; i < 10; i++) body.push_back(m[i] ? CH_ONE : CH_ZERO);
        body.push_back(CH_COMMA);
        for (int i = 0; i < 10; i++) body.push_back(o[i] ? CH_ONE : CH_ZERO);
        nStrobe = 0;
        host_u.sendCmd(body, 1'b0, 0);
        expectFrames(nRsp, CS_NORMAL, 1'b1);
        `CHK("strobes", 1, nStrobe)
        `CHK("mask", m, seenMask)
        `CHK("on bits", o, seenOn)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(28));
        errors = 0;
        nChecks = 0;
        nStrobe = 0;
        reset_n = 1'b0;
        abnormal = 1'b0;
        digIn = '0;
        anaSwitchRaw = '0;
        anaLevel = '0;
        outState = '0;
        anaLevelMode = 4'($urandom);
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        for (int r = 0; r < 3; r++) begin
            newInputs();
            repeat (15) @(negedge clk_sys);
            `CHK("early report", 0, host_u.got.size())
            expectFrames(1, CS_NORMAL, 1'b1);
            cmd(CMD_STATE, CH_ZERO, 1'b0, 0);
            expectFrames(1, CS_NORMAL, 1'b1);
        end
        abnormal = 1'b1;
        cmd(CMD_STATE, CH_ZERO, 1'b0, 0);
        expectFrames(1, CS_ABNORMAL, 1'b1);
        abnormal = 1'b0;
        onOff(1);
        cmd(CMD_STATE, CH_ZERO, 1'b0, 0);
        newInputs();
        expectFrames(2, CS_NORMAL, 1'b0);
        cmd(CMD_MODE, MODE_SET, 1'b0, 0);
        expectFrames(1, CS_NOT_RUN, 1'b1);
        `CHK("run mode", 1'b0, runMode)
        cmd(CMD_STATE, CH_ZERO, 1'b0, 0);
        newInputs();
        expectFrames(0, CS_NOT_RUN, 1'b0);
        onOff(0);
        cmd(CMD_MODE, MODE_SET, 1'b0, 0);
        expectFrames(0, CS_NOT_RUN, 1'b0);
        cmd(CMD_MODE, MODE_RUN, 1'b0, 0);
        expectFrames(1, CS_NORMAL, 1'b1);
        `CHK("run mode", 1'b1, runMode)
        cmd(CMD_STATE, CH_ZERO, 1'b1, 0);
        expectFrames(0, CS_NORMAL, 1'b0);
        cmd(CMD_STATE, CH_ZERO, 1'b0, 250);
        expectFrames(0, CS_NORMAL, 1'b0);
        cmd(CMD_STATE, CH_ZERO, 1'b0, 0);
        expectFrames(1, CS_NORMAL, 1'b1);
        results();
    end
endmodule

// >>> sim/iosr_host_model.sv
/*
 * Host program model: frames commands onto the receive stream and takes
 * response bytes with random stalls.
 * Assumes the bench seeds the random generator.
 */
module iosr_host_model
    import iosr_pkg::*;
(
    input  wire logic       clk_sys,
    output logic      [7:0] rxData,
    output logic            rxValid,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    output logic            txReady
);
    logic [7:0] got[$];

    initial begin
        rxData  = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stall at random, collect every byte taken
    always @(negedge clk_sys) begin
        txReady <= ($urandom_range(3) != 0);
    end
    always @(posedge clk_sys) begin
        if (txValid && txReady)
            got.push_back(txData);
    end

    // Nibble to ASCII hex character
    function automatic logic [7:0] hexChar(input logic [3:0] n);
        return (n < 4'd10) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    // Start, hex length, body, hex check, CR LF; gap+1 idle cycles after each byte
    task automatic sendCmd(input logic [7:0] body[$], input bit badChk, input int gap);
        logic [7:0] fr[$];
        logic [7:0] chk;
        logic [7:0] len;
        len = 8'(body.size());
        fr = {CH_START, hexChar(len[7:4]), hexChar(len[3:0])};
        fr = {fr, body};
        chk = LRC_SEED;
        for (int i = 1; i < fr.size(); i++) chk ^= fr[i];
        if (badChk)
            chk = ~chk;
        fr = {fr, hexChar(chk[7:4]), hexChar(chk[3:0]), CH_CR, CH_LF};
        foreach (fr[i]) begin
            @(negedge clk_sys);
            rxData  <= fr[i];
            rxValid <= 1'b1;
            @(negedge clk_sys);
            rxValid <= 1'b0;
            rxData  <= ~fr[i];
            repeat (gap) @(negedge clk_sys);
        end
    endtask
endmodule

// >>> src/iosr_core.sv
/*
 * Command interpreter for state reporting and Setting/Run mode control.
 * Receives framed ASCII commands as a byte stream, drives batched output
 * control, and transmits the 61-byte overall state response.
 * Assumes rx bytes arrive one per rxValid pulse and tx bytes are taken
 * by a serialiser on txValid && txReady.
 */
module iosr_core #(
    parameter int unsigned DEBOUNCE_CYCLES = iosr_pkg::DEBOUNCE_CYC,
    parameter int unsigned TIMEOUT_CYCLES  = iosr_pkg::TIMEOUT_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    input  wire logic [7:0]                  rxData,
    input  wire logic                        rxValid,
    output logic      [7:0]                  txData,
    output logic                             txValid,
    input  wire logic                        txReady,
    input  wire logic [iosr_pkg::NUM_DIN-1:0] digIn,
    input  wire logic [iosr_pkg::NUM_ANA-1:0] anaSwitchRaw,
    input  wire logic [iosr_pkg::NUM_ANA-1:0] anaLevelMode,
    input  wire logic [39:0]                 anaLevel,
    input  wire logic [29:0]                 outState,
    input  wire logic                        abnormal,
    output logic                             outCtrlStrobe,
    output logic      [iosr_pkg::NUM_OUT-1:0] outCtrlMask,
    output logic      [iosr_pkg::NUM_OUT-1:0] outCtrlOn,
    output logic                             runMode
);
    import iosr_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_LEN, RX_BODY, RX_LRC, RX_CR, RX_LF} iosr_rx_e;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] hexChar(input logic [3:0] n);
        return (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_HEXA + {4'h0, n - 4'ha};
    endfunction

    function automatic logic [4:0] charNib(input logic [7:0] c);
        if (c >= CH_ZERO && c <= CH_NINE)      return {1'b1, 4'(c - CH_ZERO)};
        else if (c >= CH_HEXA && c <= CH_HEXF) return {1'b1, 4'(c - CH_HEXA + 8'd10)};
        else                                   return 5'h00;
    endfunction

    function automatic logic [7:0] decChar(input logic [9:0] v, input int unsigned k);
        int unsigned q;
        q = 32'(v);
        for (int i = 0; i < 3; i++) if (i < 3 - k) q = q / 10;
        return CH_ZERO + 8'(q % 10);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Debounced inputs
    logic [15:0] cleanIn;
    logic        inChanged;

    iosr_debounce #(.WIDTH(16), .STABLE_CYC(DEBOUNCE_CYCLES)) uDeb (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .rawIn    ({anaSwitchRaw & ~anaLevelMode, digIn}),
        .cleanOut (cleanIn),
        .changed  (inChanged)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive parser state
    iosr_rx_e    rxState_reg;
    logic [7:0]  lenVal_reg;
    logic [7:0]  bodyCnt_reg;
    logic [7:0]  lrcAcc_reg;
    logic [7:0]  lrcRx_reg;
    logic        nibPhase_reg;
    logic [31:0] age_reg;
    logic [7:0]  body_reg [BODY_MAX];

    wire  [4:0]  nib       = charNib(rxData);
    wire         timedOut  = (rxState_reg != RX_IDLE) && (age_reg >= TIMEOUT_CYCLES - 1);
    wire         frameDone = rxValid && (rxState_reg == RX_LF) && (rxData == CH_LF);
    wire         lrcOk     = (lrcRx_reg == lrcAcc_reg);
    wire         cmdFire   = frameDone && lrcOk && (body_reg[0] == CH_ZERO);
    wire [7:0]   cmdCode   = body_reg[1];
    wire         isOnOff   = cmdFire && cmdCode == CMD_ONOFF && lenVal_reg == ONOFF_LEN;
    wire         isState   = cmdFire && cmdCode == CMD_STATE;
    wire         isSet     = cmdFire && cmdCode == CMD_MODE && body_reg[2] == MODE_SET;
    wire         isRun     = cmdFire && cmdCode == CMD_MODE && body_reg[2] == MODE_RUN;

    // Frame reception, framing and check
    always_ff @(posedge clk_sys) begin
        if (!reset_n || timedOut) begin
            rxState_reg  <= RX_IDLE;
            nibPhase_reg <= 1'b0;
        end else if (rxValid) begin
            unique case (rxState_reg)
                RX_IDLE: if (rxData == CH_START) begin
                    rxState_reg  <= RX_LEN;
                    lrcAcc_reg   <= LRC_SEED;
                    bodyCnt_reg  <= 8'h00;
                    nibPhase_reg <= 1'b0;
                end
                RX_LEN: begin
                    lrcAcc_reg   <= lrcAcc_reg ^ rxData;
                    nibPhase_reg <= ~nibPhase_reg;
                    lenVal_reg   <= {lenVal_reg[3:0], nib[3:0]};
                    if (!nib[4]) rxState_reg <= RX_IDLE;
                    else if (nibPhase_reg) rxState_reg <= RX_BODY;
                end
                RX_BODY: begin
                    lrcAcc_reg  <= lrcAcc_reg ^ rxData;
                    bodyCnt_reg <= bodyCnt_reg + 8'd1;
                    if (bodyCnt_reg < 8'(BODY_MAX)) body_reg[bodyCnt_reg[4:0]] <= rxData;
                    if (bodyCnt_reg + 8'd1 >= lenVal_reg) rxState_reg <= RX_LRC;
                end
                RX_LRC: begin
                    nibPhase_reg <= ~nibPhase_reg;
                    lrcRx_reg    <= {lrcRx_reg[3:0], nib[3:0]};
                    if (!nib[4]) rxState_reg <= RX_IDLE;
                    else if (nibPhase_reg) rxState_reg <= RX_CR;
                end
                RX_CR:   rxState_reg <= (rxData == CH_CR) ? RX_LF : RX_IDLE;
                RX_LF:   rxState_reg <= RX_IDLE;
            endcase
        end
    end

    // Frame age since start flag
    always_ff @(posedge clk_sys) begin
        if (!reset_n || rxState_reg == RX_IDLE) age_reg <= '0;
        else                                    age_reg <= age_reg + 32'd1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command effects
    logic [NUM_OUT-1:0] maskDec;
    logic [NUM_OUT-1:0] onDec;
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : gCtl
            assign maskDec[g] = (body_reg[2 + g] == CH_ONE);
            assign onDec[g]   = (body_reg[2 + ONOFF_ON0 + g] == CH_ONE);
        end
    endgenerate

    // Mode, batch strobe and batch words held until the next batch
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            runMode       <= 1'b1;
            outCtrlStrobe <= 1'b0;
            outCtrlMask   <= '0;
            outCtrlOn     <= '0;
        end else begin
            outCtrlStrobe <= isOnOff;
            if (isOnOff) outCtrlMask <= maskDec;
            if (isOnOff) outCtrlOn <= onDec;
            if (isSet) runMode <= 1'b0;
            if (isRun) runMode <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response requests: one after set, none while setting, one on run
    wire replyReq = ((isOnOff || isState) && runMode)
                    || (isSet && runMode) || isRun;
    wire eventReq = inChanged && runMode;

    logic       replyPend_reg;
    logic       eventPend_reg;
    logic       busy_reg;
    logic [5:0] idx_reg;
    logic [7:0] txLrc_reg;

    wire        txTake  = busy_reg && txReady;
    wire        txStart = !busy_reg && (replyPend_reg || eventPend_reg);

    // Pending flags; a new request wins over the clear at start
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            replyPend_reg <= 1'b0;
            eventPend_reg <= 1'b0;
        end else begin
            replyPend_reg <= replyReq || (replyPend_reg && !txStart);
            eventPend_reg <= eventReq || (eventPend_reg && !txStart && runMode);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Payload byte for position p (1..52)
    function automatic logic [7:0] payByte(input int unsigned p);
        int unsigned q;
        int unsigned k;
        int unsigned o;
        q = 0;
        k = 0;
        o = 0;
        if (p == 1) begin
            return abnormal ? CS_ABNORMAL : (runMode ? CS_NORMAL : CS_NOT_RUN);
        end else if (p < PAY_DIN0) begin
            q = p - PAY_ANA0;
            k = q / 6;
            o = q % 6;
            if (o == 5) return CH_COMMA;
            if (o == 0) return anaLevelMode[k] ? CH_NINE :
                               (cleanIn[NUM_DIN + k] ? CH_ONE : CH_ZERO);
            return decChar(anaLevel[k*10 +: 10], o - 1);
        end else begin
            q = (p < PAY_OUT0) ? p - PAY_DIN0 : p - PAY_OUT0;
            k = (q / 5) * 4 + q % 5;
            o = q % 5;
            if (o == 4) return CH_COMMA;
            if (p < PAY_OUT0) return cleanIn[k] ? CH_ONE : CH_ZERO;
            return CH_ZERO + {5'h00, outState[k*3 +: 3]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Frame byte for index n: ':' len func payload lrc CR LF
    wire [5:0] nextIdx = txStart ? 6'd0 : idx_reg + 6'd1;
    wire       inLrc   = (idx_reg >= 6'd1) && (idx_reg <= TX_PAYN);
    wire [7:0] lrcNow  = (txTake && inLrc) ? txLrc_reg ^ txData : txLrc_reg;
    logic [7:0] nextByte;

    always_comb begin
        unique case (nextIdx)
            6'd0:  nextByte = CH_START;
            6'd1:  nextByte = hexChar(RSP_LEN[7:4]);
            6'd2:  nextByte = hexChar(RSP_LEN[3:0]);
            6'd3:  nextByte = CH_ZERO;
            6'd4:  nextByte = RSP_STATE;
            6'd57: nextByte = hexChar(lrcNow[7:4]);
            6'd58: nextByte = hexChar(lrcNow[3:0]);
            6'd59: nextByte = CH_CR;
            6'd60: nextByte = CH_LF;
            default: nextByte = payByte(32'(nextIdx - TX_PAY0 + 6'd1));
        endcase
    end

    // Transmit sequencer, one frame at a time
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            busy_reg  <= 1'b0;
            idx_reg   <= 6'd0;
            txData    <= 8'h00;
            txLrc_reg <= LRC_SEED;
        end else if (txStart) begin
            busy_reg  <= 1'b1;
            idx_reg   <= 6'd0;
            txData    <= nextByte;
            txLrc_reg <= LRC_SEED;
        end else if (txTake) begin
            txLrc_reg <= lrcNow;
            if (idx_reg == TX_LAST) begin
                busy_reg <= 1'b0;
            end else begin
                idx_reg <= nextIdx;
                txData  <= nextByte;
            end
        end
    end

    assign txValid = busy_reg;
endmodule

// >>> src/iosr_debounce.sv
/*
 * Per-bit input filter: a bit's new level is accepted only after it has
 * held steady for STABLE_CYC clocks; any accepted change raises a pulse.
 * Assumes inputs already synchronous to clk_sys.
 */
module iosr_debounce #(
    parameter int unsigned WIDTH      = 16,
    parameter int unsigned STABLE_CYC = 300000
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] cleanOut,
    output logic                  changed
);
    import iosr_pkg::*;

    logic [WIDTH-1:0] flip;

    ////////////////////////////////////////////////////////////////////////////
    // One stability counter per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gBit
            logic [31:0] cnt_reg;
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    cnt_reg         <= '0;
                    cleanOut[g]     <= 1'b0;
                end else if (rawIn[g] == cleanOut[g]) begin
                    cnt_reg         <= '0;
                end else if (cnt_reg >= STABLE_CYC - 1) begin
                    cnt_reg         <= '0;
                    cleanOut[g]     <= rawIn[g];
                end else begin
                    cnt_reg         <= cnt_reg + 32'd1;
                end
            end
            assign flip[g] = (rawIn[g] != cleanOut[g]) && (cnt_reg >= STABLE_CYC - 1);
        end
    endgenerate

    // Pulse on any accepted change
    always_ff @(posedge clk_sys) begin
        if (!reset_n) changed <= 1'b0;
        else          changed <= |flip;
    end
endmodule

// >>> src/iosr_pkg.sv
/*
 * Shared constants for the I/O state report and mode control block:
 * frame characters, command codes, state codes, payload layout and timing.
 * Assumes a single 20 MHz system clock.
 */
package iosr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned DEBOUNCE_MS  = 15;
    localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned TIMEOUT_S    = 5;
    localparam int unsigned TIMEOUT_CYC  = CLK_HZ * TIMEOUT_S;

    ////////////////////////////////////////////////////////////////////////////
    // Frame characters
    localparam logic [7:0] CH_START = 8'h3a;
    localparam logic [7:0] CH_CR    = 8'h0d;
    localparam logic [7:0] CH_LF    = 8'h0a;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_NINE  = 8'h39;
    localparam logic [7:0] CH_HEXA  = 8'h41;
    localparam logic [7:0] CH_HEXF  = 8'h46;
    localparam logic [7:0] LRC_SEED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Command and response codes (second character; first is always 0x30), mode arguments (third character)
    localparam logic [7:0] CMD_ONOFF = 8'h31;
    localparam logic [7:0] RSP_STATE = 8'h32;
    localparam logic [7:0] CMD_STATE = 8'h33;
    localparam logic [7:0] CMD_MODE  = 8'h34;
    localparam logic [7:0] MODE_SET  = 8'h30;
    localparam logic [7:0] MODE_RUN  = 8'h31;

    ////////////////////////////////////////////////////////////////////////////
    // Control state codes
    localparam logic [7:0] CS_NORMAL   = 8'h30;
    localparam logic [7:0] CS_NOT_RUN  = 8'h31;
    localparam logic [7:0] CS_ABNORMAL = 8'h39;

    ////////////////////////////////////////////////////////////////////////////
    // Layout
    localparam int unsigned NUM_DIN     = 12;
    localparam int unsigned NUM_ANA     = 4;
    localparam int unsigned NUM_OUT     = 10;
    localparam int unsigned BODY_MAX    = 23;
    localparam logic [7:0]  ONOFF_LEN   = 8'd23;
    localparam int unsigned ONOFF_ON0   = 11;
    localparam logic [7:0]  RSP_LEN     = 8'h36;
    localparam int unsigned PAY_ANA0    = 2;
    localparam int unsigned PAY_DIN0    = 26;
    localparam int unsigned PAY_OUT0    = 41;
    localparam logic [5:0]  TX_PAY0     = 6'd5;
    localparam logic [5:0]  TX_PAYN     = 6'd56;
    localparam logic [5:0]  TX_LAST     = 6'd60;

endpackage
